// File: rtl/adc_rate_consts.vh
// Constants for the converter rate and clock control block.
// Assumes a single 125 MHz system clock; included by its bare name.
`ifndef ADC_RATE_CONSTS_VH
`define ADC_RATE_CONSTS_VH

// ----------------------------------------------------------------------
// Clocks (frequencies in Hz)
// ----------------------------------------------------------------------
`define MCLK_HZ 64'h0000_0000_0773_5940
`define OSC_HI_HZ 64'h0000_0000_0025_8000
`define OSC_LO_HZ 64'h0000_0000_001F_4000
`define SAMPLE_DIV 4'hA

// ----------------------------------------------------------------------
// Conversion lengths in modulator samples
// ----------------------------------------------------------------------
`define CONT_LEN_4 18'h0_1000
`define CONT_LEN_5 18'h0_0800
`define CONT_LEN_6 18'h0_0400
`define CONT_LEN_7 18'h0_0200
`define SING_LEN_0 18'h3_C000
`define SING_LEN_1 18'h1_8000
`define SING_LEN_2 18'h0_C000
`define SING_LEN_3 18'h0_6000
`define SING_LEN_4 18'h0_4000
`define SING_LEN_5 18'h0_2000
`define SING_LEN_6 18'h0_1000
`define SING_LEN_7 18'h0_0800
`define SETTLE_DROP 2'h3

// ----------------------------------------------------------------------
// Command byte fields
// ----------------------------------------------------------------------
`define CMD_START_BIT 7
`define CMD_REG_BIT 6
`define CMD_ADDR_HI 5
`define CMD_ADDR_LO 4
`define CMD_STOP_BIT 3
`define CMD_READ_BIT 0
`define CMD_RATE_HI 2

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_STATUS 2'h0
`define ADDR_CONFIG 2'h1
`define ADDR_GPIO 2'h2
`define ADDR_DATA 2'h3

// ----------------------------------------------------------------------
// First configuration register fields and reset values
// ----------------------------------------------------------------------
`define CFG_OSC_SEL 7
`define CFG_UNIPOLAR 6
`define CFG_EXT_CLK 5
`define CFG_IN_BUF 3
`define CFG_SINGLE 1
`define CFG_RESET 8'h00
`define GPIO_RESET 8'h00
`define DATA_BITS 5'h18
`define BYTE_BITS 5'h08

`endif

// File: rtl/two_entry_buffer.v
// Two-entry result buffer with valid/ready on both sides.
// Assumes one clock; in_ready and out_valid come straight from flops.
`timescale 1ns/1ps

module two_entry_buffer #(
  parameter WIDTH = 24
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] slot0;
reg [WIDTH-1:0] slot1;
reg [1:0] count;
reg [1:0] next_count;
wire push;
wire pop;

assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;
assign out_data = slot0;

always @*
begin
  next_count = count;
  if (push && !pop)
    next_count = count + 2'h1;
  else if (pop && !push)
    next_count = count - 2'h1;
end

always @(posedge clk or posedge rst)
begin
  if (rst)
  begin
    slot0 <= {WIDTH{1'b0}};
    slot1 <= {WIDTH{1'b0}};
    count <= 2'h0;
    in_ready <= 1'b1;
    out_valid <= 1'b0;
  end
  else
  begin
    if (push && pop)
    begin
      if (count == 2'h1)
        slot0 <= in_data;
      else
      begin
        slot0 <= slot1;
        slot1 <= in_data;
      end
    end
    else if (push)
    begin
      if (count == 2'h0)
        slot0 <= in_data;
      else
        slot1 <= in_data;
    end
    else if (pop)
      slot0 <= slot1;
    count <= next_count;
    // Full stops the source, so a stalled reader loses no word
    in_ready <= (next_count != 2'h2);
    out_valid <= (next_count != 2'h0);
  end
end

endmodule // two_entry_buffer

// File: rtl/adc_rate_and_clock_control.v
// Digital control of a delta-sigma converter: clock source, rates,
// configuration bits, GPIO and the serial pins.
// Assumes the serial pins are already synchronous to mclk and that the
// digital filter delivers one result word after each conv_strobe.
`timescale 1ns/1ps
`include "adc_rate_consts.vh"

// Operation
// RL1: Serial input captured on rising clock edge
// RL2: Ready/data pin low means result ready
// RL3: Ready/data pin changes only on falling edge; the code also sets it when select falls
// RL4: Serial transfers accepted only while select low
// RL5: External clock select takes clock from pin
// RL6: Rates scale with external clock frequency
// RL7: Oscillator select picks high or low frequency
// RL8: System clock divided into timing enables
// RL9: Modulator sampling is system clock over ten
// RL10: Continuous rate codes four to seven decoded
// RL11: Single-cycle rate codes zero to seven decoded
// RL12: Config bit switches input buffer
// RL13: Config bit chooses unipolar or bipolar
// RL14: Four GPIO pins controlled through registers
// RL15: Rate field comes from command byte
// RL16: Continuous results settle after three periods
// RL17: Single-cycle select chooses conversion mode
// RL18: Reset selects internal oscillator
module adc_rate_and_clock_control #(
  parameter CONV_SHIFT = 0
) (
  input wire mclk,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire din,
  output reg rdy_dout,
  output reg rdy_dout_oe,
  input wire ext_clk_in,
  output reg mod_sample,
  output reg conv_strobe,
  output reg conv_busy,
  input wire result_valid,
  output wire result_ready,
  input wire [23:0] result_data,
  output reg input_buffer_en,
  output reg unipolar_en,
  output reg clock_from_pin,
  input wire [3:0] gpio_in,
  output reg [3:0] gpio_out,
  output reg [3:0] gpio_oe
);

// ----------------------------------------------------------------------
// Oscillator phase increments
// ----------------------------------------------------------------------
localparam [63:0] INC_HI_W = (`OSC_HI_HZ << 32) / `MCLK_HZ;
localparam [63:0] INC_LO_W = (`OSC_LO_HZ << 32) / `MCLK_HZ;
localparam [31:0] INC_HI = INC_HI_W[31:0];
localparam [31:0] INC_LO = INC_LO_W[31:0];

// Serial states
localparam [2:0] S_CMD = 3'h1;
localparam [2:0] S_WR = 3'h2;
localparam [2:0] S_RD = 3'h4;

function [17:0] conv_len;
  input single;
  input [2:0] rate;
  reg [17:0] len;
  begin
    len = `CONT_LEN_4;
    if (single)
    begin
      case (rate)
        3'h0: len = `SING_LEN_0;
        3'h1: len = `SING_LEN_1;
        3'h2: len = `SING_LEN_2;
        3'h3: len = `SING_LEN_3;
        3'h4: len = `SING_LEN_4;
        3'h5: len = `SING_LEN_5;
        3'h6: len = `SING_LEN_6;
        default: len = `SING_LEN_7;
      endcase
    end
    else
    begin
      // Codes below four have no continuous rate; they run as code four
      case (rate)
        3'h5: len = `CONT_LEN_5;
        3'h6: len = `CONT_LEN_6;
        3'h7: len = `CONT_LEN_7;
        default: len = `CONT_LEN_4;
      endcase
    end
    len = len >> CONV_SHIFT;
    conv_len = (len == 18'h0_0000) ? 18'h0_0001 : len;
  end
endfunction

reg [7:0] config_reg;
reg [7:0] gpio_reg;
reg [2:0] rate_sel;
reg [31:0] phase;
reg ext_clk_d;
reg sys_tick;
reg [3:0] sample_cnt;
reg [17:0] conv_cnt;
reg [1:0] drop_cnt;
reg sclk_d;
reg cs_d;
reg [2:0] state;
reg [4:0] bit_cnt;
reg [4:0] rd_len;
reg [6:0] in_shift;
reg [23:0] out_shift;
reg [1:0] wr_addr;
reg rd_is_data;
reg buf_pop;
wire [32:0] phase_sum;
wire sclk_rise;
wire sclk_fall;
wire cs_fall;
wire [7:0] in_byte;
wire buf_valid;
wire [23:0] buf_data;
wire keep_result;

// ----------------------------------------------------------------------
// System clock and timing enables
// ----------------------------------------------------------------------
// A phase accumulator cannot hit the oscillator edges exactly; the
// average tick rate is right, with up to one mclk period of jitter.
// RL7: pick oscillator increment
assign phase_sum = {1'b0, phase} +
  {1'b0, (config_reg[`CFG_OSC_SEL] ? INC_LO : INC_HI)};

always @(posedge mclk or posedge rst)
begin
  if (rst)
  begin
    phase <= 32'h0000_0000;
    ext_clk_d <= 1'b0;
    sys_tick <= 1'b0;
    sample_cnt <= 4'h0;
    mod_sample <= 1'b0;
  end
  else
  begin
    phase <= phase_sum[31:0];
    ext_clk_d <= ext_clk_in;
    // RL5: pin edges become the system clock
    // RL6: every later count follows this tick, so rates scale
    if (config_reg[`CFG_EXT_CLK])
      sys_tick <= ext_clk_in & ~ext_clk_d;
    else
      sys_tick <= phase_sum[32];
    mod_sample <= 1'b0;
    // RL8: divide system clock into enables
    // RL9: one modulator sample per ten ticks
    if (sys_tick)
    begin
      if (sample_cnt == `SAMPLE_DIV - 4'h1)
      begin
        sample_cnt <= 4'h0;
        mod_sample <= 1'b1;
      end
      else
        sample_cnt <= sample_cnt + 4'h1;
    end
  end
end

// ----------------------------------------------------------------------
// Serial pin edges
// ----------------------------------------------------------------------
assign sclk_rise = sclk & ~sclk_d & ~cs_n;
assign sclk_fall = ~sclk & sclk_d & ~cs_n;
assign cs_fall = ~cs_n & cs_d;
assign in_byte = {in_shift, din};

// ----------------------------------------------------------------------
// Serial command, register and read logic
// ----------------------------------------------------------------------
always @(posedge mclk or posedge rst)
begin
  if (rst)
  begin
    sclk_d <= 1'b1;
    cs_d <= 1'b1;
    state <= S_CMD;
    bit_cnt <= 5'h00;
    rd_len <= `BYTE_BITS;
    in_shift <= 7'h00;
    out_shift <= 24'h00_0000;
    wr_addr <= `ADDR_STATUS;
    rd_is_data <= 1'b0;
    buf_pop <= 1'b0;
    // RL18: internal oscillator after reset
    config_reg <= `CFG_RESET;
    gpio_reg <= `GPIO_RESET;
    rdy_dout <= 1'b1;
    rdy_dout_oe <= 1'b0;
  end
  else
  begin
    sclk_d <= sclk;
    cs_d <= cs_n;
    buf_pop <= 1'b0;
    rdy_dout_oe <= ~cs_n;
    // RL4: deselect aborts any transfer
    if (cs_n)
    begin
      state <= S_CMD;
      bit_cnt <= 5'h00;
    end
    // RL1: capture on rising serial clock
    else if (sclk_rise)
    begin
      in_shift <= in_byte[6:0];
      bit_cnt <= bit_cnt + 5'h01;
      case (state)
        S_CMD:
        begin
          if (bit_cnt == `BYTE_BITS - 5'h01)
          begin
            bit_cnt <= 5'h00;
            if (in_byte[`CMD_START_BIT] && in_byte[`CMD_REG_BIT])
            begin
              wr_addr <= in_byte[`CMD_ADDR_HI:`CMD_ADDR_LO];
              if (in_byte[`CMD_READ_BIT])
              begin
                state <= S_RD;
                rd_is_data <= 1'b0;
                rd_len <= `BYTE_BITS;
                case (in_byte[`CMD_ADDR_HI:`CMD_ADDR_LO])
                  `ADDR_CONFIG: out_shift <= {config_reg, 16'h0000};
                  `ADDR_GPIO:
                    out_shift <= {gpio_reg[7:4], gpio_in, 16'h0000};
                  `ADDR_DATA:
                  begin
                    out_shift <= buf_data;
                    rd_is_data <= buf_valid;
                    rd_len <= `DATA_BITS;
                  end
                  default:
                    out_shift <= {conv_busy, buf_valid, drop_cnt,
                      1'b0, rate_sel, 16'h0000};
                endcase
              end
              else
                state <= S_WR;
            end
          end
        end
        S_WR:
        begin
          if (bit_cnt == `BYTE_BITS - 5'h01)
          begin
            state <= S_CMD;
            bit_cnt <= 5'h00;
            if (wr_addr == `ADDR_CONFIG)
              config_reg <= in_byte;
            // RL14: direction and level of the GPIO pins
            else if (wr_addr == `ADDR_GPIO)
              gpio_reg <= in_byte;
          end
        end
        S_RD:
        begin
          if (bit_cnt == rd_len - 5'h01)
          begin
            state <= S_CMD;
            bit_cnt <= 5'h00;
            buf_pop <= rd_is_data;
          end
        end
        default:
          state <= S_CMD;
      endcase
    end
    // RL3: pin changes on falling edges, and also when select falls
    if (sclk_fall)
    begin
      if (state == S_RD)
      begin
        rdy_dout <= out_shift[23];
        out_shift <= {out_shift[22:0], 1'b0};
      end
      else
        // RL2: low level flags a waiting result
        rdy_dout <= ~buf_valid;
    end
    // The pin also needs a defined level as soon as it is driven
    else if (cs_fall)
      rdy_dout <= ~buf_valid;
  end
end

// ----------------------------------------------------------------------
// Configuration outputs and GPIO
// ----------------------------------------------------------------------
always @(posedge mclk or posedge rst)
begin
  if (rst)
  begin
    input_buffer_en <= 1'b0;
    unipolar_en <= 1'b0;
    clock_from_pin <= 1'b0;
    gpio_out <= 4'h0;
    gpio_oe <= 4'h0;
  end
  else
  begin
    // RL12: input buffer switch
    input_buffer_en <= config_reg[`CFG_IN_BUF];
    // RL13: unipolar when set, bipolar when clear
    unipolar_en <= config_reg[`CFG_UNIPOLAR];
    clock_from_pin <= config_reg[`CFG_EXT_CLK];
    // RL14: GPIO pins follow their register
    gpio_out <= gpio_reg[3:0];
    gpio_oe <= gpio_reg[7:4];
  end
end

// ----------------------------------------------------------------------
// Conversion timing
// ----------------------------------------------------------------------
always @(posedge mclk or posedge rst)
begin
  if (rst)
  begin
    rate_sel <= 3'h0;
    conv_busy <= 1'b0;
    conv_cnt <= 18'h0_0000;
    conv_strobe <= 1'b0;
    drop_cnt <= 2'h0;
  end
  else
  begin
    conv_strobe <= 1'b0;
    if (result_valid && result_ready && drop_cnt != 2'h0)
      drop_cnt <= drop_cnt - 2'h1;
    if (sclk_rise && state == S_CMD &&
        bit_cnt == `BYTE_BITS - 5'h01 &&
        in_byte[`CMD_START_BIT] && !in_byte[`CMD_REG_BIT])
    begin
      // RL15: rate taken from the command byte
      rate_sel <= in_byte[`CMD_RATE_HI:0];
      conv_busy <= ~in_byte[`CMD_STOP_BIT];
      conv_cnt <= 18'h0_0000;
      // RL16: continuous mode discards three unsettled results
      // RL17: single-cycle mode keeps the first
      drop_cnt <= config_reg[`CFG_SINGLE] ? 2'h0 : `SETTLE_DROP;
    end
    else if (conv_busy && mod_sample)
    begin
      // RL10: continuous lengths per rate code
      // RL11: single-cycle lengths per rate code
      if (conv_cnt == conv_len(config_reg[`CFG_SINGLE], rate_sel) - 18'h1)
      begin
        conv_cnt <= 18'h0_0000;
        conv_strobe <= 1'b1;
        // RL17: single-cycle stops after one result
        if (config_reg[`CFG_SINGLE])
          conv_busy <= 1'b0;
      end
      else
        conv_cnt <= conv_cnt + 18'h0_0001;
    end
  end
end

// ----------------------------------------------------------------------
// Result buffer
// ----------------------------------------------------------------------
// RL16: unsettled results are accepted and dropped
assign keep_result = result_valid & (drop_cnt == 2'h0);

two_entry_buffer #(
  .WIDTH(24)
) u_result_buffer (
  .clk(mclk),
  .rst(rst),
  .in_valid(keep_result),
  .in_ready(result_ready),
  .in_data(result_data),
  .out_valid(buf_valid),
  .out_ready(buf_pop),
  .out_data(buf_data)
);

endmodule // adc_rate_and_clock_control

// File: tb/adc_rate_and_clock_control_assertions.sv
// Port checker for the rate and clock control block.
// Assumes it is bound into every instance of that block.
`timescale 1ns/1ps
module adc_rate_and_clock_control_assertions #(
  parameter CONV_SHIFT = 0
) (
  input wire mclk,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire rdy_dout,
  input wire rdy_dout_oe,
  input wire mod_sample,
  input wire conv_strobe,
  input wire conv_busy,
  input wire input_buffer_en,
  input wire unipolar_en,
  input wire clock_from_pin,
  input wire [3:0] gpio_out,
  input wire [3:0] gpio_oe
);
  // ------
  // Checks
  // ------
  reg [3:0] sh;
  reg [3:0] ch;
  wire rise_any;
  wire fall_any;
  wire cs_fall;
  wire sel_seen;
  // Four samples of history cover the edge detect and output lag
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sh <= 4'hF;
      ch <= 4'hF;
    end
    else
    begin
      sh <= {sh[2:0], sclk};
      ch <= {ch[2:0], cs_n};
    end
  end
  assign rise_any = |({sh[2:0], sclk} & ~sh);
  assign fall_any = |(~{sh[2:0], sclk} & sh);
  assign cs_fall = |(~{ch[2:0], cs_n} & ch);
  assign sel_seen = ~&{ch, cs_n};

  oe_follows_cs_a: assert property (
    @(posedge mclk) disable iff (rst) rdy_dout_oe == !$past(cs_n))
    else $error("pin enable off select");
  dout_on_fall_a: assert property (
    @(posedge mclk) disable iff (rst)
    !$stable(rdy_dout) |-> fall_any || cs_fall)
    else $error("data pin moved without fall");
  cfg_on_rise_a: assert property (
    @(posedge mclk) disable iff (rst)
    !$stable({unipolar_en, input_buffer_en, clock_from_pin})
    |-> rise_any && sel_seen)
    else $error("config moved without rise");
  gpio_on_rise_a: assert property (
    @(posedge mclk) disable iff (rst)
    !$stable({gpio_oe, gpio_out}) |-> rise_any && sel_seen)
    else $error("gpio moved without rise");
  busy_on_rise_a: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(conv_busy) |-> rise_any && sel_seen)
    else $error("busy rose without command");
  strobe_after_sample_a: assert property (
    @(posedge mclk) disable iff (rst) conv_strobe |-> $past(mod_sample))
    else $error("strobe not after sample");
  strobe_pulse_a: assert property (
    @(posedge mclk) disable iff (rst) conv_strobe |=> !conv_strobe [*8])
    else $error("strobe too long");
  sample_gap_a: assert property (
    @(posedge mclk) disable iff (rst) mod_sample |=> !mod_sample [*8])
    else $error("samples too close");
  strobe_while_busy_a: assert property (
    @(posedge mclk) disable iff (rst) conv_strobe |-> $past(conv_busy))
    else $error("strobe while idle");
endmodule // adc_rate_and_clock_control_assertions

bind adc_rate_and_clock_control adc_rate_and_clock_control_assertions
  #(.CONV_SHIFT(CONV_SHIFT)) i_adc_rate_and_clock_control_assertions (
  .mclk, .rst, .cs_n, .sclk, .rdy_dout, .rdy_dout_oe, .mod_sample,
  .conv_strobe, .conv_busy, .input_buffer_en, .unipolar_en,
  .clock_from_pin, .gpio_out, .gpio_oe);

// File: tb/host_model.sv
// Host controller model for the serial pins.
// Assumes mclk paces it; sclk idles low and moves between frames only when xbyte is called on its own.
`timescale 1ns/1ps
module host_model (
  input wire mclk,
  input wire rdy_dout,
  input wire rdy_dout_oe,
  output reg cs_n,
  output reg sclk,
  output reg din
);
  // ------
  // Pins
  // ------
  reg last;
  wire line;
  // No pull resistor: a released pin shows the inverse of its last level
  assign line = rdy_dout_oe ? rdy_dout : ~last;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    last = 1'b1;
  end
  always @(posedge mclk)
    last <= line;
  task xbyte(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        @(posedge mclk);
        sclk <= 1'b0;
        din <= tx[i];
        repeat (3) @(posedge mclk);
        #1;
        rx[i] = line;
        @(posedge mclk);
        sclk <= 1'b1;
        @(posedge mclk);
      end
    end
  endtask
  task frame(input [7:0] c, input [7:0] d, input integer nb,
    output reg rdy, output reg [23:0] w);
    reg [7:0] r;
    integer j;
    begin
      @(posedge mclk);
      cs_n <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      rdy = line;
      xbyte(c, r);
      w = 24'h00_0000;
      for (j = 0; j < nb; j = j + 1)
      begin
        xbyte(d, r);
        w = {w[15:0], r};
      end
      @(posedge mclk);
      sclk <= 1'b0;
      repeat (3) @(posedge mclk);
      cs_n <= 1'b1;
      din <= ~din;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule // host_model

// File: tb/tb_adc_rate_and_clock_control.sv
// Self-checking bench for the rate and clock control block.
// Assumes the host model drives the serial pins; the bench is the filter.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    n_compared = n_compared + 1; \
    if ((g) !== (e)) \
    begin \
      fail_count = fail_count + 1; \
      $display("[FAIL] %s exp %0h got %0h", n, e, g); \
    end \
  end
module tb_adc_rate_and_clock_control;
  // ------
  // Setup
  // ------
  // Single lengths of the rules divided by 512 (CONV_SHIFT 9)
  localparam [71:0] SLEN = {9'h1E0, 9'h0C0, 9'h060, 9'h030,
    9'h020, 9'h010, 9'h008, 9'h004};
  reg mclk, rst, ext_clk_in, e, result_valid, rdy;
  reg [23:0] result_data, w;
  reg [3:0] gpio_in, r;
  reg [7:0] b;
  wire cs_n, sclk, din, rdy_dout, rdy_dout_oe, mod_sample, conv_strobe;
  wire conv_busy, result_ready, input_buffer_en, unipolar_en;
  wire clock_from_pin;
  wire [3:0] gpio_out, gpio_oe;
  integer fail_count, n_compared, tick, t0, k, busy_mods, conv_mods;
  adc_rate_and_clock_control #(.CONV_SHIFT(9)) i_adc_rate_and_clock_control (
    .mclk, .rst, .cs_n, .sclk, .din, .rdy_dout, .rdy_dout_oe, .ext_clk_in,
    .mod_sample, .conv_strobe, .conv_busy, .result_valid, .result_ready,
    .result_data, .input_buffer_en, .unipolar_en, .clock_from_pin,
    .gpio_in, .gpio_out, .gpio_oe);
  host_model i_host_model (.mclk, .rdy_dout, .rdy_dout_oe, .cs_n, .sclk,
    .din);
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    e <= ~e;
    if (e)
      ext_clk_in <= ~ext_clk_in;
  end
  // Samples per conversion, counted while busy
  always @(posedge mclk)
  begin
    tick <= tick + 1;
    if (conv_strobe)
    begin
      conv_mods <= busy_mods;
      busy_mods <= 0;
    end
    else if (!conv_busy)
      busy_mods <= 0;
    else if (mod_sample)
      busy_mods <= busy_mods + 1;
  end
  task finish_test;
    begin
      if (fail_count == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task till(input integer strobe);
    begin
      k = 0;
      @(posedge mclk);
      #1;
      while ((strobe ? conv_strobe : mod_sample) !== 1'b1 && k < 25000)
      begin
        @(posedge mclk);
        #1;
        k = k + 1;
      end
      @(posedge mclk);
      #1;
    end
  endtask
  task period;
    begin
      till(0);
      till(0);
      t0 = tick;
      repeat (10) till(0);
      t0 = tick - t0;
    end
  endtask
  task push(input [23:0] v);
    begin
      @(posedge mclk);
      result_valid <= 1'b1;
      result_data <= v;
      k = 0;
      #1;
      while (result_ready !== 1'b1 && k < 60)
      begin
        @(posedge mclk);
        #1;
        k = k + 1;
      end
      @(posedge mclk);
      result_valid <= 1'b0;
      result_data <= ~v;
    end
  endtask
  task rd(input [7:0] c, input [7:0] d, input integer nb);
    i_host_model.frame(c, d, nb, rdy, w);
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk);
    fail_count = fail_count + 1;
    finish_test;
  end
  // ------
  // Tests
  // ------
  initial
  begin
    {fail_count, n_compared, tick, busy_mods, conv_mods} = 0;
    {e, ext_clk_in, result_valid, result_data} = 0;
    rst = 1'b1;
    gpio_in = 4'h3;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("clock_from_pin", 1'b0, clock_from_pin)
    // Clocking with select high must be ignored
    i_host_model.xbyte(8'hD0, b);
    i_host_model.xbyte(8'h4A, b);
    `CHK("unselected", 1'b0, unipolar_en)
    rd(8'hD0, 8'h4A, 1);
    `CHK("cfg_out", 3'h6, {unipolar_en, input_buffer_en, clock_from_pin})
    rd(8'hD1, 8'h00, 1);
    `CHK("cfg_read", 8'h4A, w[7:0])
    rd(8'hE0, 8'h5A, 1);
    `CHK("gpio_drive", 8'h5A, {gpio_oe, gpio_out})
    rd(8'hE1, 8'h00, 1);
    `CHK("gpio_read", 8'h53, w[7:0])
    period;
    `CHK("period_hi", 1'b1, t0 >= 5084 && t0 <= 5089)
    rd(8'hD0, 8'hCA, 1);
    period;
    `CHK("period_lo", 1'b1, t0 >= 6101 && t0 <= 6106)
    rd(8'hD0, 8'h20, 1);
    period;
    `CHK("period_ext", 1'b1, t0 >= 398 && t0 <= 402)
    for (r = 4'h4; r < 4'h8; r = r + 4'h1)
    begin
      rd({5'h10, r[2:0]}, 8'h00, 0);
      till(1);
      till(1);
      `CHK("cont_len", 8 >> (r - 4), conv_mods)
    end
    rd(8'h88, 8'h00, 0);
    `CHK("stopped", 1'b0, conv_busy)
    rd(8'hD0, 8'h22, 1);
    for (r = 4'h0; r < 4'h8; r = r + 4'h1)
    begin
      rd({5'h10, r[2:0]}, 8'h00, 0);
      till(1);
      `CHK("single_len", SLEN[(7 - r) * 9 +: 9], conv_mods[8:0])
      `CHK("single_idle", 1'b0, conv_busy)
    end
    rd(8'hD0, 8'h20, 1);
    rd(8'h87, 8'h00, 0);
    for (r = 4'h0; r < 4'h5; r = r + 4'h1)
      push(24'hA5_5A00 + r);
    // Let the buffer's full flag settle past the edge that took the word
    #1;
    `CHK("full_refuse", 1'b0, result_ready)
    rd(8'hF1, 8'h00, 3);
    `CHK("ready_low", 1'b0, rdy)
    `CHK("word_3", 24'hA5_5A03, w)
    rd(8'hF1, 8'h00, 3);
    `CHK("word_4", 24'hA5_5A04, w)
    rd(8'hC1, 8'h00, 1);
    `CHK("ready_high", 1'b1, rdy)
    `CHK("status", 8'h87, w[7:0] & 8'hC7)
    rd(8'h88, 8'h00, 0);
    rd(8'hD0, 8'h22, 1);
    rd(8'h87, 8'h00, 0);
    push(24'h3C_C3A5);
    rd(8'hF1, 8'h00, 3);
    `CHK("single_word", 24'h3C_C3A5, w)
    finish_test;
  end
endmodule // tb_adc_rate_and_clock_control
